// ===== rtl/bus_term_pkg.sv
// shared constants and carriers for the bus cycle termination block
package bus_term_pkg;

   // -----------------------------------------------------------------
   // vector numbers
   // -----------------------------------------------------------------
   localparam logic [7:0] AUTOVEC_BASE = 8'h18;   // level plus this
   localparam logic [7:0] SPURIOUS_VEC = 8'h18;   // spurious interrupt

   // -----------------------------------------------------------------
   // timing counts
   // -----------------------------------------------------------------
   localparam logic [1:0] LATE_GAP = 2'h2;        // states to late sample

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      TERM_NONE,
      TERM_NORMAL,
      TERM_HALT,
      TERM_BUS_ERROR_IN,
      TERM_RETRY
   } term_e;

   // one sampled set of termination inputs
   typedef struct packed {
      logic ack;     // any data_size_ack line asserted
      logic autovector_request;    // autovector_request asserted
      logic bus_error_in;    // bus_error_in asserted
      logic halt;    // halt asserted
   } term_in_s;

   // cycle descriptor kept for retry
   typedef struct packed {
      logic [23:0] addr;
      logic [2:0] fc;
      logic [1:0] size;
      logic rw;
   } cyc_s;

endpackage : bus_term_pkg

// ===== rtl/bus_cycle_termination_logic.sv
// termination, exception and autovector logic for the external bus
`timescale 1ns/1ps
`default_nettype none

module bus_cycle_termination_logic
   import bus_term_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // cycle requests from the core side
   input wire logic cyc_start,
   input wire cyc_s cyc_info,
   input wire logic iack_cycle,
   input wire logic [2:0] iack_level,
   input wire logic iack_cs_autovec,
   input wire logic iack_timeout,
   input wire logic prefetch,
   input wire logic prefetch_used,
   input wire logic flow_change,
   input wire logic even_state,
   // pins from outside, active low except data_in
   input wire logic [1:0] data_size_ack_n,
   input wire logic autovector_request_n,
   input wire logic bus_error_in_n,
   input wire logic halt_n,
   input wire logic [7:0] data_in,
   // results to the core side
   output logic address_strobe,
   output cyc_s bus_cyc,
   output logic cyc_done,
   output term_e term_kind,
   output logic bus_error_in_exception,
   output logic data_suspect,
   output logic [7:0] vector_out,
   output logic vector_valid,
   output logic bus_stopped
);

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic [4:0] sync1_q; // first stage, read only by second stage
   logic [4:0] sync2_q; // safe samples
   // pins may change at any time; two stages before use
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1_q <= 5'h1F;
         sync2_q <= 5'h1F;
      end
      else
      begin
         sync1_q <= {data_size_ack_n, autovector_request_n,
                     bus_error_in_n, halt_n};
         sync2_q <= sync1_q;
      end
   end

   // -----------------------------------------------------------------
   // decoded inputs
   // -----------------------------------------------------------------
   term_in_s now; // current sample, active high
   assign now.ack = ~(sync2_q[4] & sync2_q[3]);
   assign now.autovector_request = ~sync2_q[2] | (iack_cycle & iack_cs_autovec);
   assign now.bus_error_in = ~sync2_q[1] | (iack_cycle & iack_timeout);
   assign now.halt = ~sync2_q[0];

   // -----------------------------------------------------------------
   // cycle state
   // -----------------------------------------------------------------
   typedef enum {ST_IDLE, ST_WAIT, ST_LATE, ST_HALTED, ST_RETRY} st_e;
   st_e st_q;
   cyc_s cyc_q; // held access info for rerun
   logic iack_q; // current cycle is an acknowledge
   logic [2:0] lvl_q; // pending interrupt level
   logic pf_q; // current cycle is a prefetch
   logic pf_err_q; // deferred prefetch error
   logic [1:0] gap_q; // even states left to late sample
   logic autovector_request_hit_q; // acknowledge ended by autovector
   logic [7:0] vec_q; // latched vector

   // -----------------------------------------------------------------
   // termination resolution
   // -----------------------------------------------------------------
   wire first_any = now.ack | now.autovector_request | now.bus_error_in;
   wire is_retry = now.bus_error_in & now.halt;
   wire is_bus_error_in = now.bus_error_in & ~now.halt;
   wire is_halt = now.halt & ~now.bus_error_in & (now.ack | now.autovector_request);
   wire is_norm = (now.ack | now.autovector_request) & ~now.halt;
   term_e first_kind;
   // retry before error before halt before normal
   assign first_kind = is_retry ? TERM_RETRY :
                       is_bus_error_in ? TERM_BUS_ERROR_IN :
                       is_halt ? TERM_HALT :
                       is_norm ? TERM_NORMAL : TERM_NONE;
   // late sample: error alone or with halt upgrades the end
   term_e late_kind;
   assign late_kind = is_retry ? TERM_RETRY :
                      is_bus_error_in ? TERM_BUS_ERROR_IN : TERM_NONE;
   // strobe must already be out: answers left over from the cycle before
   // are still in the synchroniser when a new cycle enters the wait state
   wire sample_n = even_state & (st_q == ST_WAIT) & address_strobe
                   & first_any;
   wire sample_late = even_state & (st_q == ST_LATE) & (gap_q == 2'h1);
   wire [7:0] auto_vec = AUTOVEC_BASE + {5'h00, lvl_q};

   // -----------------------------------------------------------------
   // main sequencer
   // -----------------------------------------------------------------
   term_e pend_q; // kind found at sample N
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= ST_IDLE;
         cyc_q <= '0;
         iack_q <= 1'b0;
         lvl_q <= 3'h0;
         pf_q <= 1'b0;
         gap_q <= 2'h0;
         pend_q <= TERM_NONE;
         autovector_request_hit_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            // new cycle accepted only while idle
            ST_IDLE:
            begin
               if (cyc_start)
               begin
                  cyc_q <= cyc_info;
                  iack_q <= iack_cycle;
                  lvl_q <= iack_level;
                  pf_q <= prefetch;
                  st_q <= ST_WAIT;
               end
            end
            // first qualifying even-state sample
            ST_WAIT:
            begin
               if (sample_n)
               begin
                  pend_q <= first_kind;
                  autovector_request_hit_q <= now.autovector_request & ~now.ack;
                  gap_q <= LATE_GAP;
                  st_q <= ST_LATE;
               end
            end
            // second look two even states later
            ST_LATE:
            begin
               if (even_state)
                  gap_q <= gap_q - 2'h1;
               if (sample_late)
               begin
                  if (late_kind != TERM_NONE)
                     pend_q <= late_kind;
                  if (late_kind == TERM_RETRY || (late_kind == TERM_NONE
                      && (pend_q == TERM_RETRY || pend_q == TERM_HALT)))
                     st_q <= (late_kind == TERM_RETRY
                              || pend_q == TERM_RETRY)
                             ? ST_RETRY : ST_HALTED;
                  else
                     st_q <= ST_IDLE;
               end
            end
            // bus stopped until halt released
            ST_HALTED:
            begin
               if (!now.halt)
                  st_q <= ST_IDLE;
            end
            // wait for both released, then rerun same cycle
            ST_RETRY:
            begin
               if (!now.halt && !now.bus_error_in)
                  st_q <= ST_WAIT;
            end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // results and outputs, all registered
   // -----------------------------------------------------------------
   wire end_now = sample_late;
   term_e fin_kind;
   assign fin_kind = (late_kind != TERM_NONE) ? late_kind : pend_q;
   wire spurious = iack_q & (fin_kind == TERM_BUS_ERROR_IN);
   // prefetch errors wait for use; flow change discards them
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         address_strobe <= 1'b0;
         bus_cyc <= '0;
         cyc_done <= 1'b0;
         term_kind <= TERM_NONE;
         bus_error_in_exception <= 1'b0;
         data_suspect <= 1'b0;
         vec_q <= 8'h00;
         vector_out <= 8'h00;
         vector_valid <= 1'b0;
         bus_stopped <= 1'b0;
         pf_err_q <= 1'b0;
      end
      else
      begin
         // strobe drops the same way for every ending
         address_strobe <= (st_q == ST_WAIT) || (st_q == ST_LATE
                           && !end_now);
         bus_cyc <= cyc_q;
         if (iack_q)
            bus_cyc.addr[3:1] <= lvl_q;
         cyc_done <= end_now;
         if (end_now)
            term_kind <= fin_kind;
         data_suspect <= end_now & (fin_kind == TERM_BUS_ERROR_IN) & now.ack;
         vector_valid <= end_now & iack_q & (fin_kind == TERM_NORMAL
                         || fin_kind == TERM_HALT || spurious);
         if (end_now && iack_q)
            vec_q <= spurious ? SPURIOUS_VEC :
                     autovector_request_hit_q ? auto_vec : data_in;
         vector_out <= (end_now && iack_q)
                       ? (spurious ? SPURIOUS_VEC
                          : autovector_request_hit_q ? auto_vec : data_in) : vec_q;
         bus_error_in_exception <= (end_now & (fin_kind == TERM_BUS_ERROR_IN) & ~pf_q
                            & ~iack_q) | (pf_err_q & prefetch_used
                            & ~flow_change);
         if (end_now && pf_q && fin_kind == TERM_BUS_ERROR_IN)
            pf_err_q <= 1'b1;
         else if (flow_change || prefetch_used)
            pf_err_q <= 1'b0;
         bus_stopped <= (st_q == ST_HALTED) || (st_q == ST_RETRY);
      end
   end

endmodule : bus_cycle_termination_logic

`default_nettype wire

// ===== test/ext_responder.sv
// far-side model: drives the termination pins from the requested answer
`timescale 1ns/1ps
`default_nettype none
module ext_responder
   import bus_term_pkg::*;
(
   // clock and strobe from the device
   input wire logic clk,
   input wire logic address_strobe,
   // what the far side should answer
   input wire term_in_s resp,
   // pins, active low, pulled up
   output logic [1:0] data_size_ack_n,
   output logic autovector_request_n,
   output logic bus_error_in_n,
   output logic halt_n
);
   // -----------------------------------------------------------------
   // pin drivers
   // -----------------------------------------------------------------
   // pins move only on rising edges so joint pins meet one sample
   always_ff @(posedge clk)
   begin
      // answers drop once the strobe goes, before the next state two
      data_size_ack_n <= {2{~(resp.ack & address_strobe)}};
      autovector_request_n <= ~(resp.autovector_request & address_strobe);
      bus_error_in_n <= ~(resp.bus_error_in & address_strobe);
      // halt is not tied to the strobe, so it outlives bus error
      halt_n <= ~resp.halt;
   end
endmodule : ext_responder
`default_nettype wire

// ===== test/bus_term_checker.sv
// concurrent checks on the termination block ports
`timescale 1ns/1ps
`default_nettype none
module bus_term_checker
   import bus_term_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cyc_start,
   input wire logic [2:0] iack_level,
   input wire logic iack_cs_autovec,
   input wire logic autovector_request_n,
   input wire logic halt_n,
   input wire logic address_strobe,
   input wire cyc_s bus_cyc,
   input wire logic cyc_done,
   input wire term_e term_kind,
   input wire logic bus_error_in_exception,
   input wire logic data_suspect,
   input wire logic [7:0] vector_out,
   input wire logic vector_valid,
   input wire logic bus_stopped
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [2:0] lvl_q; // level of the cycle in flight
   logic av_q; // an autovector answer was seen
   always_ff @(posedge clk)
   begin
      if (rst || cyc_start)
      begin
         lvl_q <= rst ? 3'h0 : iack_level;
         av_q <= 1'b0;
      end
      else if (!autovector_request_n || iack_cs_autovec)
         av_q <= 1'b1;
   end
   sequence s_begin;
      $rose(address_strobe);
   endsequence
   done_pulse_a: assert property (cyc_done |=> !cyc_done)
      else $error("end pulse too long");
   strobe_end_a: assert property (cyc_done |-> !address_strobe)
      else $error("strobe still active at end");
   cycle_ends_a: assert property (s_begin |-> ##[1:80] cyc_done)
      else $error("cycle never ended");
   bus_error_in_kind_a: assert property (bus_error_in_exception && cyc_done |-> term_kind == TERM_BUS_ERROR_IN)
      else $error("exception without bus error end");
   autovec_a: assert property (vector_valid && av_q |-> vector_out == AUTOVEC_BASE + {5'h0, lvl_q})
      else $error("autovector wrong");
   spur_noexc_a: assert property (vector_valid |-> !bus_error_in_exception)
      else $error("vector with exception");
   suspect_a: assert property (data_suspect |-> term_kind == TERM_BUS_ERROR_IN)
      else $error("suspect data without bus error");
   halt_hold_a: assert property (bus_stopped && !halt_n |=> bus_stopped)
      else $error("resumed while halted");
   stop_idle_a: assert property (bus_stopped |-> !address_strobe)
      else $error("bus active while stopped");
   retry_same_a: assert property (bus_stopped |=> $stable(bus_cyc))
      else $error("cycle changed across retry");
endmodule : bus_term_checker
`default_nettype wire
bind bus_cycle_termination_logic bus_term_checker u_bus_term_checker (.clk,
   .rst, .cyc_start, .iack_level, .iack_cs_autovec, .autovector_request_n,
   .halt_n, .address_strobe, .bus_cyc, .cyc_done, .term_kind,
   .bus_error_in_exception, .data_suspect, .vector_out, .vector_valid, .bus_stopped);

// ===== test/bus_cycle_termination_logic_tb.sv
// self-checking bench for the termination block
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_termination_logic_tb;
   import bus_term_pkg::*;
   `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
      n_mismatch++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
      end end
   logic clk = 0, rst = 1, cyc_start = 0, iack_cycle = 0, cs_av = 0;
   logic tmo = 0, even = 0;
   logic [2:0] lvl = 3'h0;
   cyc_s ci = '0, ci_save;
   term_in_s resp = '0; // far-side answer
   logic [1:0] ack_n;
   logic av_n, be_n, ht_n, as, done, bexc, susp, vval, stopped;
   cyc_s bcyc;
   term_e kind;
   logic [7:0] vec;
   int n_mismatch = 0, num_checks = 0;
   initial forever #10 clk = ~clk;
   // even bus state marker on every other edge
   always @(posedge clk) even <= #2 ~even;
   bus_cycle_termination_logic u_bus_cycle_termination_logic (.clk, .rst,
      .cyc_start, .cyc_info(ci), .iack_cycle, .iack_level(lvl),
      .iack_cs_autovec(cs_av), .iack_timeout(tmo), .prefetch(1'b0),
      .prefetch_used(1'b0), .flow_change(1'b0), .even_state(even),
      .data_size_ack_n(ack_n), .autovector_request_n(av_n),
      .bus_error_in_n(be_n), .halt_n(ht_n), .data_in(8'hFF),
      .address_strobe(as), .bus_cyc(bcyc), .cyc_done(done),
      .term_kind(kind), .bus_error_in_exception(bexc), .data_suspect(susp),
      .vector_out(vec), .vector_valid(vval), .bus_stopped(stopped));
   ext_responder u_ext_responder (.clk, .address_strobe(as), .resp,
      .data_size_ack_n(ack_n), .autovector_request_n(av_n),
      .bus_error_in_n(be_n), .halt_n(ht_n));
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   // start one cycle with the given answer, wait for its end
   task run(input logic ia, input logic [2:0] lv, input term_in_s r);
      int i;
      begin
         @(posedge clk); #2 resp = r; cyc_start = 1; iack_cycle = ia;
         lvl = lv; ci.addr = ci.addr + 24'h10; ci.fc = ia ? 3'h7 : 3'h5;
         @(posedge clk); #2 cyc_start = 0;
         i = 0;
         do begin @(posedge clk); #1 i++; end while (done !== 1'b1 && i < 80);
         `CHK(done, 1'b1)
      end
   endtask : run
   initial
   begin
      repeat (3) @(posedge clk);
      #2 rst = 0;
      run(0, 0, 4'b1000); `CHK(kind, TERM_NORMAL)
      `CHK(bexc, 1'b0)
      $display("normal done");
      run(0, 0, 4'b0010); `CHK(kind, TERM_BUS_ERROR_IN)
      `CHK(bexc, 1'b1)
      run(0, 0, 4'b1010); `CHK(kind, TERM_BUS_ERROR_IN)
      `CHK(susp, 1'b1)
      $display("bus error done");
      for (int l = 1; l < 8; l++)
      begin
         run(1, l[2:0], 4'b0100); `CHK(vec, 8'h18 + l[7:0])
         `CHK(vval, 1'b1)
      end
      $display("autovector done");
      cs_av = 1; run(1, 3'h3, 4'b0000); `CHK(vec, 8'h1B)
      cs_av = 0; tmo = 1; run(1, 3'h6, 4'b0000); `CHK(vec, SPURIOUS_VEC)
      `CHK(bexc, 1'b0)
      tmo = 0;
      $display("acknowledge answers done");
      run(0, 0, 4'b1001); `CHK(kind, TERM_HALT)
      repeat (4) @(posedge clk); `CHK(stopped, 1'b1)
      #2 resp = '0; repeat (6) @(posedge clk); `CHK(stopped, 1'b0)
      $display("halt done");
      run(0, 0, 4'b0011); `CHK(kind, TERM_RETRY)
      ci_save = ci;
      #2 resp = 4'b1001; repeat (5) @(posedge clk); `CHK(stopped, 1'b1)
      `CHK(as, 1'b0)
      #2 resp = 4'b1000;
      do begin @(posedge clk); #1; end while (done !== 1'b1);
      `CHK(kind, TERM_NORMAL)
      `CHK(bcyc, ci_save)
      $display("retry done");
      run(0, 0, 4'b1000); repeat (2) @(posedge clk); #2 resp.bus_error_in = 1;
      @(posedge clk); #1 `CHK(bexc, 1'b0)
      resp = '0; run(0, 0, 4'b1000); `CHK(kind, TERM_NORMAL)
      conclude();
   end
   // watchdog far beyond the few hundred cycles the tests take
   initial
   begin
      #400000 n_mismatch++;
      conclude();
   end
endmodule : bus_cycle_termination_logic_tb
`default_nettype wire
